// ### sim/clock_divider_config_regs_checker.sv
// concurrent checks on the configuration bank's top-level ports.
// assumes one system clock domain with an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module clock_divider_config_regs_checker
  import clock_divider_config_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic write_accepted_out,
  input wire logic write_refused_out,
  input wire logic config_write_lock_out,
  input wire logic first_sync_start_out,
  input wire logic second_sync_start_out,
  input wire logic first_sync_on_write_out,
  input wire logic second_sync_on_write_out,
  input wire logic soft_reset_active_out,
  input wire logic device_powerdown_out,
  input wire logic [OUTPUT_COUNT*WIDE_FORMAT_WIDTH-1:0]
    output_format_field_out,
  input wire logic [9:0] digital_delay_cycles_out,
  input wire logic [10:0] group3_output_divide_out,
  input wire logic [2:0] first_input_divide_out
);
  // every check below lives in the system clock domain
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  a_accept_one_cycle: assert property (
    write_accepted_out |=> !write_accepted_out)
    else $error("accept pulse longer than one cycle");
  a_refuse_one_cycle: assert property (
    write_refused_out |=> !write_refused_out)
    else $error("refuse pulse longer than one cycle");
  a_refuse_needs_lock: assert property (
    write_refused_out |-> config_write_lock_out && !write_accepted_out)
    else $error("write refused while unlocked");
  a_locked_fields_hold: assert property (
    config_write_lock_out |=> $stable({device_powerdown_out,
      output_format_field_out, digital_delay_cycles_out}))
    else $error("locked field changed");
  a_first_sync_cause: assert property (
    first_sync_start_out |-> write_accepted_out && first_sync_on_write_out)
    else $error("first sync without enabled write");
  a_second_sync_cause: assert property (
    second_sync_start_out |-> write_accepted_out && second_sync_on_write_out)
    else $error("second sync without enabled write");
  a_soft_reset_defaults: assert property (
    $rose(soft_reset_active_out) |-> digital_delay_cycles_out == 10'h005 &&
      group3_output_divide_out == 11'h001 && first_input_divide_out == 3'h2
      && !config_write_lock_out)
    else $error("soft reset did not load defaults");
  a_reset_bit_clears: assert property (
    $fell(soft_reset_active_out) |-> write_accepted_out)
    else $error("reset bit cleared without a write");
  a_fields_need_write: assert property (
    $changed({device_powerdown_out, output_format_field_out,
      digital_delay_cycles_out}) |-> write_accepted_out)
    else $error("field changed without accepted write");
  a_narrow_top_zero: assert property (
    {output_format_field_out[15], output_format_field_out[11],
      output_format_field_out[7], output_format_field_out[3]} == 4'h0)
    else $error("narrow format lane top bit set");
endmodule

bind clock_divider_config_regs clock_divider_config_regs_checker i_checker (
  .clk_sys_in, .rst_b_in, .write_accepted_out, .write_refused_out,
  .config_write_lock_out, .first_sync_start_out, .second_sync_start_out,
  .first_sync_on_write_out, .second_sync_on_write_out,
  .soft_reset_active_out, .device_powerdown_out, .output_format_field_out,
  .digital_delay_cycles_out, .group3_output_divide_out,
  .first_input_divide_out
);
`default_nettype wire

// ### sim/serial_host_model.sv
// host controller model driving the three-wire serial write port.
// assumes the bench calls send() only after the bank is out of reset.
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
  output logic serial_clock_out,
  output logic serial_data_out,
  output logic latch_strobe_out
);
  // serial clock stands still between frames
  initial
  begin
    serial_clock_out = 1'b0;
    serial_data_out = 1'b0;
    latch_strobe_out = 1'b0;
  end

  // one 32-bit word, msb first, then a strobe held for hold_ns
  task automatic send(input logic [31:0] w, input int hold_ns);
    for (int i = 31; i >= 0; i--)
    begin
      serial_data_out = w[i];
      #62.5 serial_clock_out = 1'b1;
      #62.5 serial_clock_out = 1'b0;
    end
    serial_data_out = ~w[0]; // released line shows no stale bit
    latch_strobe_out = 1'b1;
    #(hold_ns) latch_strobe_out = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

// ### sim/tb_clock_divider_config_regs.sv
// self-checking bench for the configuration bank with a serial host model.
// assumes expected images come from the package defaults and written words.
`timescale 1ns/100ps
`default_nettype none
module tb_clock_divider_config_regs;
  import clock_divider_config_pkg::*;
  logic clk_sys_in;
  logic rst_b_in;
  wire logic sclk;
  wire logic sdata;
  wire logic strobe;
  wire logic [125:0] got; // field outputs packed per register
  wire logic [3:0] pulse; // accept, refuse, first sync, second sync
  reg_image_type img; // expected register contents
  logic lk;
  logic sr;
  int want[4] = '{0, 0, 0, 0};
  int seen[4] = '{0, 0, 0, 0};
  int failures = 0;
  int total_checks = 0;

  serial_host_model i_serial_host_model (.serial_clock_out(sclk),
    .serial_data_out(sdata), .latch_strobe_out(strobe));

  clock_divider_config_regs i_clock_divider_config_regs (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .serial_clock_in(sclk),
    .serial_data_in(sdata), .latch_strobe_in(strobe),
    .soft_reset_active_out(got[0]), .device_powerdown_out(got[109]),
    .group_a_low_powerdown_out(got[110]),
    .group_a_high_powerdown_out(got[111]),
    .group_b_low_powerdown_out(got[112]),
    .group_b_high_powerdown_out(got[113]),
    .first_input_buffer_kind_out(got[114]),
    .second_input_buffer_kind_out(got[115]),
    .first_input_divide_out(got[118:116]),
    .first_input_divide_bypass_out(got[120:119]),
    .second_input_divide_out(got[123:121]),
    .second_input_divide_bypass_out(got[125:124]),
    .output_format_field_out(got[108:53]),
    .analog_delay_value_out(got[39:34]), .delay_half_shift_out(got[40]),
    .second_sync_qualify_out(got[42:41]),
    .first_sync_polarity_out(got[43]), .second_sync_polarity_out(got[44]),
    .skip_sync_group_out(got[48:45]),
    .first_sync_quick_enable_out(got[49]),
    .second_sync_quick_enable_out(got[50]),
    .first_sync_on_write_out(got[51]), .second_sync_on_write_out(got[52]),
    .digital_delay_cycles_out(got[33:24]),
    .group0_output_divide_out(got[4:2]), .group1_output_divide_out(got[7:5]),
    .group2_output_divide_out(got[10:8]), .out12_delay_route_out(got[11]),
    .out13_delay_route_out(got[12]), .group3_output_divide_out(got[23:13]),
    .config_write_lock_out(got[1]), .first_sync_start_out(pulse[2]),
    .second_sync_start_out(pulse[3]), .write_accepted_out(pulse[0]),
    .write_refused_out(pulse[1]));

  // system clock, 40 ns period
  initial
  begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // pulses last one cycle, so count them at every falling edge
  always @(negedge clk_sys_in)
    for (int k = 0; k < 4; k++)
      if (pulse[k] === 1'b1)
        seen[k]++;

  // expected outputs worked out from register images
  function automatic logic [125:0] fields(input reg_image_type r,
    input logic l, input logic s);
    logic [55:0] f;
    for (int i = 0; i < 4; i++)
      f[4*i+:4] = {1'b0, r[1][4+3*i+:3]};
    for (int i = 4; i < 8; i++)
      f[4*i+:4] = r[1][4*i+:4];
    for (int i = 8; i < 14; i++)
      f[4*i+:4] = r[2][4*(i-7)+:4];
    return {r[0][23:14], r[0][11:5], f, r[3][26:23], r[3][19:14],
      r[3][12:4], r[4][13:4], r[5][27:17], r[5][14:4], l, s};
  endfunction

  task automatic compare_fields();
    total_checks++;
    if (got !== fields(img, lk, sr))
    begin
      failures++;
      $display("[FAIL] %0t fields %h expected %h", $time, got,
        fields(img, lk, sr));
    end
  endtask

  task automatic compare_count(input int g, input int e);
    total_checks++;
    if (g != e)
    begin
      failures++;
      $display("[FAIL] %0t pulse count %0d expected %0d", $time, g, e);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // reset held 12 cycles; model falls back to silicon defaults
  task automatic do_reset();
    @(negedge clk_sys_in);
    rst_b_in = 1'b0;
    repeat (12) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    img = {DEFAULT_DIVIDE_SELECT, DEFAULT_DIGITAL_DELAY,
      DEFAULT_SYNC_AND_ADELAY, DEFAULT_FORMAT_HIGH, DEFAULT_FORMAT_LOW,
      DEFAULT_INPUT_AND_POWER};
    lk = DEFAULT_LOCK;
    sr = 1'b0;
    repeat (3) @(negedge clk_sys_in);
  endtask

  // update the model, send the word, then check every result
  task automatic write_word(input logic [31:0] w);
    logic [3:0] a;
    a = w[3:0];
    if (a == ADDR_WRITE_LOCK)
    begin
      lk = w[LOCK_BIT];
      sr = 1'b0;
      want[0]++;
    end
    else if (a > ADDR_DIVIDE_SELECT)
      a = a; // unmapped words change nothing
    else if (lk)
      want[1]++; // locked words dropped, reset bit kept
    else
    begin
      want[0]++;
      if (a == ADDR_DIVIDE_SELECT && img[3][FIRST_AUTO_BIT])
        want[2]++;
      if (a >= ADDR_DIGITAL_DELAY && img[3][SECOND_AUTO_BIT])
        want[3]++;
      if (a == ADDR_INPUT_AND_POWER && w[SOFT_RESET_BIT])
      begin
        img = {DEFAULT_DIVIDE_SELECT, DEFAULT_DIGITAL_DELAY,
          DEFAULT_SYNC_AND_ADELAY, DEFAULT_FORMAT_HIGH, DEFAULT_FORMAT_LOW,
          DEFAULT_INPUT_AND_POWER};
        sr = 1'b1;
      end
      else
      begin
        img[a[2:0]] = w;
        sr = 1'b0;
      end
    end
    @(negedge clk_sys_in);
    i_serial_host_model.send(w, ($urandom % 2) ? 240 : 400);
    compare_fields();
    for (int k = 0; k < 4; k++)
      compare_count(seen[k], want[k]);
  endtask

  // a hang ends the run as a mismatch
  initial
  begin
    #4000000;
    $display("[FAIL] %0t timeout", $time);
    failures++;
    results();
  end

  initial
  begin
    logic [31:0] w;
    rst_b_in = 1'b0;
    void'($urandom(32'h78acdf90));
    do_reset();
    compare_fields();
    $display("test defaults done");
    for (int i = 0; i < LOCKABLE_COUNT; i++)
      write_word({28'($urandom), 4'(i)} & 32'hffff_ffef);
    write_word({28'hfff_ffff, ADDR_INPUT_AND_POWER});
    write_word({28'h0, ADDR_DIVIDE_SELECT});
    $display("test field and soft reset done");
    write_word({28'h1, ADDR_WRITE_LOCK});
    write_word({28'hfff_ffff, ADDR_DIGITAL_DELAY});
    write_word({28'hfff_ffff, ADDR_INPUT_AND_POWER});
    write_word({28'hfff_ffff, 4'h9});
    write_word({28'h0, ADDR_WRITE_LOCK});
    $display("test lock and unmapped done");
    repeat (40)
    begin
      w = $urandom;
      if ($urandom % 4 != 0)
        w[SOFT_RESET_BIT] = 1'b0;
      write_word(w);
    end
    $display("test random words done");
    do_reset();
    compare_fields();
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire

// ### src/clock_divider_config_pkg.sv
// constants of the divider configuration bank: addresses, field positions
// and the silicon default images loaded at power-up or software reset.
// assumes a 32-bit serial word with the register address in bits 3:0.
package clock_divider_config_pkg;

  // serial word layout
  localparam int WORD_WIDTH = 32;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_WIDTH = 4;

  // register addresses
  localparam logic [3:0] ADDR_INPUT_AND_POWER = 4'h0;
  localparam logic [3:0] ADDR_FORMAT_LOW = 4'h1;
  localparam logic [3:0] ADDR_FORMAT_HIGH = 4'h2;
  localparam logic [3:0] ADDR_SYNC_AND_ADELAY = 4'h3;
  localparam logic [3:0] ADDR_DIGITAL_DELAY = 4'h4;
  localparam logic [3:0] ADDR_DIVIDE_SELECT = 4'h5;
  localparam logic [3:0] ADDR_WRITE_LOCK = 4'hf;
  localparam int LOCKABLE_COUNT = 6;

  // input_and_power_control fields
  localparam int SOFT_RESET_BIT = 4;
  localparam int POWERDOWN_BIT = 5;
  localparam int GROUP_PD_LSB = 6;
  localparam int GROUP_COUNT = 4;
  localparam int FIRST_BUF_BIT = 10;
  localparam int SECOND_BUF_BIT = 11;
  localparam int FIRST_DIV_LSB = 14;
  localparam int FIRST_BYPASS_LSB = 17;
  localparam int SECOND_DIV_LSB = 19;
  localparam int SECOND_BYPASS_LSB = 22;

  // output format fields
  localparam int OUTPUT_COUNT = 14;
  localparam int NARROW_FORMAT_COUNT = 4;
  localparam int NARROW_FORMAT_WIDTH = 3;
  localparam int WIDE_FORMAT_WIDTH = 4;
  localparam int FORMAT_LOW_LSB = 4;
  localparam int FORMAT_LOW_WIDE_LSB = 16;
  localparam int FORMAT_LOW_LAST = 7;
  localparam int FORMAT_HIGH_LSB = 4;

  // sync_and_analog_delay fields
  localparam int ADELAY_LSB = 4;
  localparam int HALF_SHIFT_BIT = 10;
  localparam int QUALIFY_LSB = 11;
  localparam int FIRST_POL_BIT = 14;
  localparam int SECOND_POL_BIT = 15;
  localparam int SKIP_SYNC_LSB = 16;
  localparam int FIRST_QUICK_BIT = 23;
  localparam int SECOND_QUICK_BIT = 24;
  localparam int FIRST_AUTO_BIT = 25;
  localparam int SECOND_AUTO_BIT = 26;

  // digital_delay_count, output_divide_select and write lock fields
  localparam int DDELAY_LSB = 4;
  localparam int GROUP0_DIV_LSB = 4;
  localparam int GROUP1_DIV_LSB = 7;
  localparam int GROUP2_DIV_LSB = 10;
  localparam int OUT12_ROUTE_BIT = 13;
  localparam int OUT13_ROUTE_BIT = 14;
  localparam int GROUP3_DIV_LSB = 17;
  localparam int LOCK_BIT = 4;

  // silicon default images of the lockable registers, and the lock default
  localparam logic [31:0] DEFAULT_INPUT_AND_POWER = 32'h0010_8000;
  localparam logic [31:0] DEFAULT_FORMAT_LOW = 32'h1111_2490;
  localparam logic [31:0] DEFAULT_FORMAT_HIGH = 32'h0111_1110;
  localparam logic [31:0] DEFAULT_SYNC_AND_ADELAY = 32'h0600_c000;
  localparam logic [31:0] DEFAULT_DIGITAL_DELAY = 32'h0000_0050;
  localparam logic [31:0] DEFAULT_DIVIDE_SELECT = 32'h0002_0490;
  localparam logic DEFAULT_LOCK = 1'b0;

  // latch strobe synchroniser depth in system clocks
  localparam int STROBE_SYNC_STAGES = 2;

  typedef logic [LOCKABLE_COUNT-1:0][WORD_WIDTH-1:0] reg_image_type;

endpackage

// ### src/clock_divider_config_regs.sv
// configuration register bank of a dual-bank clock divider, loaded over a
// three-wire serial write port (serial clock, data, latch strobe).
// assumes the host holds the serial clock still while the strobe is high,
// long enough for three system clocks, so the shifted word is quiescent.
//
// Overview of operation
// R1 - power-up or soft reset loads silicon defaults
// R2 - reg0 bit4 soft reset, default clear
// R3 - reg0 bit5 global powerdown, default active
// R4 - reg0 bits6-9 group powerdowns, default up
// R5 - reg0 bits10-11 input buffer kinds, default bipolar
// R6 - reg0 input divides at 14 and 19
// R7 - reg0 divide bypass selects, default bypass
// R8 - reg1 three-bit formats outputs 0-3, LVDS
// R9 - four-bit formats outputs 4-13, default LVDS
// R10 - reg3 bits4-9 analog delay, default zero
// R11 - reg3 bit10 half-cycle digital delay shift
// R12 - reg3 bits11-12 second sync qualification
// R13 - reg3 bits14-15 sync polarity, default high
// R14 - reg3 bits16-19 skip group sync
// R15 - reg3 bit25 auto first sync on reg5
// R16 - reg3 bit26 auto second sync reg4/5
// R17 - reg4 bits4-13 digital delay, default five
// R18 - reg5 group divides 0-2, default one
// R19 - reg5 bits13-14 route outputs through delay
// R20 - reg5 bits17-27 shared divide, default one
// R21 - reg15 bit4 lock blocks regs 0-5
// R22 - word: address bits 3:0, data above
// R23 - shift MSB first, sample rising clock
// R24 - strobe pulse high transfers word to register
// R25 - reset bit clears on other write, masks
// R26 - unknown addresses are ignored
`timescale 1ns/100ps
`default_nettype none
module clock_divider_config_regs
  import clock_divider_config_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic latch_strobe_in,
  output logic soft_reset_active_out,
  output logic device_powerdown_out,
  output logic group_a_low_powerdown_out,
  output logic group_a_high_powerdown_out,
  output logic group_b_low_powerdown_out,
  output logic group_b_high_powerdown_out,
  output logic first_input_buffer_kind_out,
  output logic second_input_buffer_kind_out,
  output logic [2:0] first_input_divide_out,
  output logic [1:0] first_input_divide_bypass_out,
  output logic [2:0] second_input_divide_out,
  output logic [1:0] second_input_divide_bypass_out,
  output logic [OUTPUT_COUNT*WIDE_FORMAT_WIDTH-1:0] output_format_field_out,
  output logic [5:0] analog_delay_value_out,
  output logic delay_half_shift_out,
  output logic [1:0] second_sync_qualify_out,
  output logic first_sync_polarity_out,
  output logic second_sync_polarity_out,
  output logic [GROUP_COUNT-1:0] skip_sync_group_out,
  output logic first_sync_quick_enable_out,
  output logic second_sync_quick_enable_out,
  output logic first_sync_on_write_out,
  output logic second_sync_on_write_out,
  output logic [9:0] digital_delay_cycles_out,
  output logic [2:0] group0_output_divide_out,
  output logic [2:0] group1_output_divide_out,
  output logic [2:0] group2_output_divide_out,
  output logic out12_delay_route_out,
  output logic out13_delay_route_out,
  output logic [10:0] group3_output_divide_out,
  output logic config_write_lock_out,
  output logic first_sync_start_out,
  output logic second_sync_start_out,
  output logic write_accepted_out,
  output logic write_refused_out
);

  // word path from the link-side shifter
  serial_word_if word_link ();

  // link-domain shifter; it runs only while the host clocks words in
  serial_word_shifter #(
    .WIDTH(WORD_WIDTH)
  ) shifter_inst (
    .serial_clock_in(serial_clock_in),
    .rst_b_in(rst_b_in),
    .serial_data_in(serial_data_in),
    .latch_strobe_in(latch_strobe_in),
    .word_port(word_link.shifter)
  );

  // all state of the system-clock side
  typedef struct packed {
    // strobe synchroniser
    logic [STROBE_SYNC_STAGES-1:0] strobe_sync;
    // last synchronised strobe level
    logic strobe_prev;
    // lockable register images 0 to 5
    reg_image_type images;
    // write lock bit
    logic lock;
    // reset bit as last written
    logic soft_reset;
    // one-cycle auto sync requests
    logic first_sync_start;
    logic second_sync_start;
    // one-cycle write outcome pulses
    logic accepted;
    logic refused;
  } bank_state_type;

  bank_state_type state;
  bank_state_type next_state;

  // decode helpers for the word being latched
  // synchronised strobe edge
  logic strobe_rise;
  // address field of the word
  logic [ADDR_WIDTH-1:0] word_addr;
  // address names registers 0 to 5
  logic addr_lockable;
  // address names any implemented register
  logic addr_known;

  // the word is only sampled after the strobe crossed two flops; the
  // shifter holds still then, so the bus needs no further handshake
  always_comb
  begin
    strobe_rise = state.strobe_sync[STROBE_SYNC_STAGES-1]
      && !state.strobe_prev; // [R24]
    word_addr =
      word_link.shift_word[ADDR_LSB +: ADDR_WIDTH]; // [R22]
    // only registers 0 to 5 lock
    addr_lockable = (word_addr < ADDR_WIDTH'(LOCKABLE_COUNT));
    addr_known =
      addr_lockable || (word_addr == ADDR_WRITE_LOCK); // [R26]
  end

  // next-state logic of the bank
  always_comb
  begin
    next_state = state;
    // strobe crossing: only the second stage is read by logic
    next_state.strobe_sync = {state.strobe_sync[STROBE_SYNC_STAGES-2:0],
      latch_strobe_in};
    next_state.strobe_prev = state.strobe_sync[STROBE_SYNC_STAGES-1];

    // pulses last one cycle unless renewed
    next_state.first_sync_start = 1'b0;
    next_state.second_sync_start = 1'b0;
    next_state.accepted = 1'b0;
    next_state.refused = 1'b0;
    // other addresses: no store, no pulse
    if (strobe_rise && addr_known)
    begin
      if (addr_lockable && state.lock)
      begin
        // locked registers keep their values; report the refusal
        next_state.refused = 1'b1; // [R21]
      end
      else if (word_addr == ADDR_WRITE_LOCK)
      begin
        // the lock itself stays writable so it can be released
        next_state.lock = word_link.shift_word[LOCK_BIT]; // [R21]
        next_state.soft_reset = 1'b0; // [R25]
        next_state.accepted = 1'b1;
      end
      else if (word_addr == ADDR_INPUT_AND_POWER
        && word_link.shift_word[SOFT_RESET_BIT])
      begin
        // soft reset: every other bit of this word is ignored
        next_state.images[0] = DEFAULT_INPUT_AND_POWER; // [R1] [R2] [R25]
        next_state.images[1] = DEFAULT_FORMAT_LOW; // [R1]
        next_state.images[2] = DEFAULT_FORMAT_HIGH; // [R1]
        next_state.images[3] = DEFAULT_SYNC_AND_ADELAY; // [R1]
        next_state.images[4] = DEFAULT_DIGITAL_DELAY; // [R1]
        next_state.images[5] = DEFAULT_DIVIDE_SELECT; // [R1]
        // a soft reset also unlocks
        next_state.lock = DEFAULT_LOCK; // [R1]
        next_state.soft_reset = 1'b1; // [R2]
        next_state.accepted = 1'b1;
      end
      else
      begin
        // ordinary write into the addressed image [R24]
        next_state.images[word_addr[2:0]] = word_link.shift_word;
        next_state.soft_reset = 1'b0; // [R25]
        next_state.accepted = 1'b1;
        // auto sync uses the sync settings in force before this write
        if (word_addr == ADDR_DIVIDE_SELECT)
        begin
          next_state.first_sync_start =
            state.images[3][FIRST_AUTO_BIT]; // [R15]
        end
        if (word_addr == ADDR_DIVIDE_SELECT
          || word_addr == ADDR_DIGITAL_DELAY)
        begin
          next_state.second_sync_start =
            state.images[3][SECOND_AUTO_BIT]; // [R16]
        end
      end
    end
  end

  // register the state; power-up loads the silicon defaults [R1]
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      // idle-low start: no false edge
      state.strobe_sync <= '0;
      state.strobe_prev <= 1'b0;
      state.images[0] <= DEFAULT_INPUT_AND_POWER;
      state.images[1] <= DEFAULT_FORMAT_LOW;
      state.images[2] <= DEFAULT_FORMAT_HIGH;
      state.images[3] <= DEFAULT_SYNC_AND_ADELAY;
      state.images[4] <= DEFAULT_DIGITAL_DELAY;
      state.images[5] <= DEFAULT_DIVIDE_SELECT;
      state.lock <= DEFAULT_LOCK;
      state.soft_reset <= 1'b0;
      state.first_sync_start <= 1'b0;
      state.second_sync_start <= 1'b0;
      state.accepted <= 1'b0;
      state.refused <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // input and power fields straight from the register image, except soft reset, which comes from its own flag
  // reserved bits drive no output
  assign soft_reset_active_out =
    state.soft_reset; // [R2]
  assign device_powerdown_out =
    state.images[0][POWERDOWN_BIT]; // [R3]
  assign group_a_low_powerdown_out =
    state.images[0][GROUP_PD_LSB]; // [R4]
  assign group_a_high_powerdown_out =
    state.images[0][GROUP_PD_LSB+1]; // [R4]
  assign group_b_low_powerdown_out =
    state.images[0][GROUP_PD_LSB+2]; // [R4]
  assign group_b_high_powerdown_out =
    state.images[0][GROUP_PD_LSB+3]; // [R4]
  assign first_input_buffer_kind_out =
    state.images[0][FIRST_BUF_BIT]; // [R5]
  assign second_input_buffer_kind_out =
    state.images[0][SECOND_BUF_BIT]; // [R5]
  assign first_input_divide_out =
    state.images[0][FIRST_DIV_LSB +: 3]; // [R6]
  assign second_input_divide_out =
    state.images[0][SECOND_DIV_LSB +: 3]; // [R6]
  assign first_input_divide_bypass_out =
    state.images[0][FIRST_BYPASS_LSB +: 2]; // [R7]
  assign second_input_divide_bypass_out =
    state.images[0][SECOND_BYPASS_LSB +: 2]; // [R7]

  // per-output format fields; the first four are three bits wide and
  // read back with a zero top bit so every lane is four bits
  genvar out_idx;
  generate
    for (out_idx = 0; out_idx < OUTPUT_COUNT; out_idx++)
    begin : format_lane
      if (out_idx < NARROW_FORMAT_COUNT)
      begin : narrow
        assign output_format_field_out[out_idx*WIDE_FORMAT_WIDTH +:
          WIDE_FORMAT_WIDTH] = {1'b0, state.images[1][FORMAT_LOW_LSB
          + out_idx*NARROW_FORMAT_WIDTH +: NARROW_FORMAT_WIDTH]}; // [R8]
      end
      else if (out_idx <= FORMAT_LOW_LAST)
      begin : wide_low
        assign output_format_field_out[out_idx*WIDE_FORMAT_WIDTH +:
          WIDE_FORMAT_WIDTH] = state.images[1][FORMAT_LOW_WIDE_LSB
          + (out_idx-NARROW_FORMAT_COUNT)*WIDE_FORMAT_WIDTH +:
          WIDE_FORMAT_WIDTH]; // [R9]
      end
      else
      begin : wide_high
        assign output_format_field_out[out_idx*WIDE_FORMAT_WIDTH +:
          WIDE_FORMAT_WIDTH] = state.images[2][FORMAT_HIGH_LSB
          + (out_idx-FORMAT_LOW_LAST-1)*WIDE_FORMAT_WIDTH +:
          WIDE_FORMAT_WIDTH]; // [R9]
      end
    end
  endgenerate

  // sync and analog delay fields
  assign analog_delay_value_out =
    state.images[3][ADELAY_LSB +: 6]; // [R10]
  assign delay_half_shift_out =
    state.images[3][HALF_SHIFT_BIT]; // [R11]
  assign second_sync_qualify_out =
    state.images[3][QUALIFY_LSB +: 2]; // [R12]
  assign first_sync_polarity_out =
    state.images[3][FIRST_POL_BIT]; // [R13]
  assign second_sync_polarity_out =
    state.images[3][SECOND_POL_BIT]; // [R13]
  assign skip_sync_group_out =
    state.images[3][SKIP_SYNC_LSB +: GROUP_COUNT]; // [R14]
  assign first_sync_quick_enable_out =
    state.images[3][FIRST_QUICK_BIT];
  assign second_sync_quick_enable_out =
    state.images[3][SECOND_QUICK_BIT];
  assign first_sync_on_write_out =
    state.images[3][FIRST_AUTO_BIT]; // [R15]
  assign second_sync_on_write_out =
    state.images[3][SECOND_AUTO_BIT]; // [R16]

  // digital delay and divider fields
  assign digital_delay_cycles_out =
    state.images[4][DDELAY_LSB +: 10]; // [R17]
  assign group0_output_divide_out =
    state.images[5][GROUP0_DIV_LSB +: 3]; // [R18]
  assign group1_output_divide_out =
    state.images[5][GROUP1_DIV_LSB +: 3]; // [R18]
  assign group2_output_divide_out =
    state.images[5][GROUP2_DIV_LSB +: 3]; // [R18]
  assign out12_delay_route_out =
    state.images[5][OUT12_ROUTE_BIT]; // [R19]
  assign out13_delay_route_out =
    state.images[5][OUT13_ROUTE_BIT]; // [R19]
  assign group3_output_divide_out =
    state.images[5][GROUP3_DIV_LSB +: 11]; // [R20]

  // lock, sync requests and write outcome, all registered
  // sync timing lives outside this bank
  assign config_write_lock_out =
    state.lock; // [R21]
  assign first_sync_start_out =
    state.first_sync_start;
  assign second_sync_start_out =
    state.second_sync_start;
  assign write_accepted_out =
    state.accepted;
  assign write_refused_out =
    state.refused;

endmodule
`default_nettype wire

// ### src/serial_word_if.sv
// carries the shifted serial word from the link-side shifter to the
// register bank; the word is only read while the latch strobe is high.
`timescale 1ns/100ps
`default_nettype none
interface serial_word_if
  import clock_divider_config_pkg::*;
  ();
  logic [WORD_WIDTH-1:0] shift_word; // word held in the link shifter
  modport shifter (output shift_word);
  modport bank (input shift_word);
endinterface
`default_nettype wire

// ### src/serial_word_shifter.sv
// link-side shift register of the three-wire serial write port.
// runs on the host's serial clock, which may stop between words.
`timescale 1ns/100ps
`default_nettype none
module serial_word_shifter
  import clock_divider_config_pkg::*;
#(
  parameter int WIDTH = WORD_WIDTH
)
(
  input wire logic serial_clock_in,
  input wire logic rst_b_in,
  input wire logic serial_data_in,
  input wire logic latch_strobe_in,
  serial_word_if.shifter word_port
);

  // all shifter state
  typedef struct packed {
    logic [WIDTH-1:0] shift; // bits collected so far, newest in bit 0
  } shift_state_type;

  shift_state_type state;
  shift_state_type next_state;

  // shift while the strobe is low; the first bit sent ends up at the top
  always_comb
  begin
    next_state = state;
    if (!latch_strobe_in)
    begin
      next_state.shift = {state.shift[WIDTH-2:0], serial_data_in}; // [R23]
    end
  end

  // register the state on the rising serial clock edge [R23]
  always_ff @(posedge serial_clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // the word stands still once the host stops clocking
  assign word_port.shift_word = state.shift;

endmodule
`default_nettype wire
